// ===== design/dtpc_timer.sv
// dual 16-bit down counter timer with pwm, input capture and dual timer modes
// assumes a wishbone classic master on i_clk; slow clock and timer pin are asynchronous
//
// Behaviour
// - each counter selects no clock, prescaled system clock or slow clock
// - five-bit down counter divides system clock by divisor plus one
// - reset clears divisor register and prescaler down counter
// - slow clock synchronised into system clock domain before use
// - counters hold while system clock stops, resume when it restarts
// - both counters disabled after reset until software configures them
// - pwm mode reloads counter one alternately from a then b
// - first pwm reload after a start from no clock or another mode comes from a
// - pwm with toggling inverts timer pin on every counter one underflow
// - pwm sets a pending on a reload, b pending on b reload
// - in pwm and capture modes counter two underflow flags source d
// - capture mode copies counter one into a on selected pin edge
// - with capture preset, store count then force counter one to all ones
// - capture sets a on pin edge and c on counter one underflow
// - dual mode reloads counter one from a, toggling pin if enabled
// - dual mode sets c pending on each low-to-high pin toggle
// - dual mode reloads counter two from b and sets d pending
// - a, b, c combine into interrupt one; d alone drives interrupt two
// - mode field: 00 pwm, 01 capture, 10 dual, 11 reserved
// - clock select: 000 none, 001 prescaled, 100 slow, others reserved
// - edge bit 0 selects falling, 1 selects rising edges
// - toggled pin starts at the programmed initial level
`timescale 1ns/1ps
`default_nettype none
module dtpc_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_slow_clk,
  input  wire logic        i_timer_pin,
  output logic             o_timer_pin,
  output logic             o_timer_pin_oe_n,
  output logic             o_timer_irq_one_line,
  output logic             o_timer_irq_two_line
);
  dtpc_pkg::dtpc_state_t s_q;
  dtpc_pkg::dtpc_state_t s_d;

  // tick for a counter from its clock select code
  function automatic logic sel_tick(input logic [2:0] sel, input logic presc,
                                    input logic slow);
    case (sel)
      dtpc_pkg::CSEL_PRESC: sel_tick = presc;
      dtpc_pkg::CSEL_SLOW:  sel_tick = slow;
      default:              sel_tick = 1'b0;   // none and reserved codes stop
    endcase
  endfunction

  logic        presc_tick;
  logic        slow_rise;
  logic        pin_edge;
  logic        tick1;
  logic        tick2;
  logic        uf1;
  logic        uf2;
  logic        wr;
  logic        rd;
  logic        clr_wr;
  logic [3:0]  set_pnd;
  logic [31:0] rd_val;
  logic        tog_pin;

  always_comb begin
    s_d = s_q;
    set_pnd = 4'h0;
    rd_val = 32'h0000_0000;
    wr = i_wb_cyc && i_wb_stb && i_wb_we && !s_q.ack && i_wb_sel[0];
    rd = i_wb_cyc && i_wb_stb && !i_wb_we && !s_q.ack;
    clr_wr = wr && (i_wb_adr == dtpc_pkg::ADR_INTCLR);

    // prescaler: tick when down counter reaches zero, then reload the divisor
    presc_tick = (s_q.presc_cnt == 5'h00);
    s_d.presc_cnt = presc_tick ? s_q.prescale_divisor : s_q.presc_cnt - 5'h01;

    // three-stage synchronisers; only the second and third stages are compared
    s_d.slow_sync = {s_q.slow_sync[1:0], i_slow_clk};
    s_d.pin_sync  = {s_q.pin_sync[1:0], i_timer_pin};
    if (s_q.slow_sync[1] == s_q.slow_sync[2]) begin
      s_d.slow_lvl = s_q.slow_sync[2];
    end
    if (s_q.pin_sync[1] == s_q.pin_sync[2]) begin
      s_d.pin_lvl = s_q.pin_sync[2];
    end
    slow_rise = s_d.slow_lvl && !s_q.slow_lvl;
    pin_edge = (s_d.pin_lvl != s_q.pin_lvl) && (s_d.pin_lvl == s_q.capture_edge_polarity);

    tick1 = sel_tick(s_q.first_counter_clock_sel, presc_tick, slow_rise);
    tick2 = sel_tick(s_q.second_counter_clock_sel, presc_tick, slow_rise);
    uf1 = tick1 && (s_q.counter_one == 16'h0000);
    uf2 = tick2 && (s_q.counter_two == 16'h0000);
    tog_pin = 1'b0;

    // counter two: same in every mode, reload from b at underflow
    if (uf2) begin
      s_d.counter_two = s_q.reload_b;
      set_pnd[3] = 1'b1;
    end else if (tick2) begin
      s_d.counter_two = s_q.counter_two - 16'h0001;
    end

    case (s_q.mode_select_field)
      dtpc_pkg::MODE_PWM: begin
        if (uf1) begin
          s_d.counter_one = s_q.next_from_b ? s_q.reload_b : s_q.reload_capture_a;
          s_d.next_from_b = !s_q.next_from_b;
          set_pnd[0] = !s_q.next_from_b;
          set_pnd[1] = s_q.next_from_b;
          tog_pin = 1'b1;
        end else if (tick1) begin
          s_d.counter_one = s_q.counter_one - 16'h0001;
        end
      end
      dtpc_pkg::MODE_CAPT: begin
        if (pin_edge) begin
          s_d.reload_capture_a = s_q.counter_one;
          set_pnd[0] = 1'b1;
          if (s_q.pin_toggle_enable) begin
            s_d.counter_one = dtpc_pkg::CNT_ALL_ONES;
          end else if (tick1) begin
            s_d.counter_one = s_q.counter_one - 16'h0001;
          end
        end else if (tick1) begin
          // capture mode has no reload: counter wraps through all ones
          s_d.counter_one = s_q.counter_one - 16'h0001;
        end
        if (uf1) begin
          set_pnd[2] = 1'b1;
        end
      end
      dtpc_pkg::MODE_DUAL: begin
        if (uf1) begin
          s_d.counter_one = s_q.reload_capture_a;
          tog_pin = 1'b1;
          set_pnd[2] = s_q.pin_toggle_enable && !s_q.timer_pin;
        end else if (tick1) begin
          s_d.counter_one = s_q.counter_one - 16'h0001;
        end
      end
      default: begin
        // reserved mode: counter one holds
      end
    endcase

    // a restart (clock deselected or another mode) makes the next pwm reload come from a
    if (s_q.first_counter_clock_sel == dtpc_pkg::CSEL_NONE ||
        s_q.mode_select_field != dtpc_pkg::MODE_PWM) begin
      s_d.next_from_b = 1'b0;
    end

    if (tog_pin && s_q.pin_toggle_enable) begin
      s_d.timer_pin = !s_q.timer_pin;
    end

    // register writes; a hardware load in the same cycle loses to software
    if (wr) begin
      case (i_wb_adr)
        dtpc_pkg::ADR_PRESCALE: s_d.prescale_divisor = i_wb_dat[4:0];
        dtpc_pkg::ADR_CLKSEL: begin
          s_d.first_counter_clock_sel  = i_wb_dat[2:0];
          s_d.second_counter_clock_sel = i_wb_dat[5:3];
        end
        dtpc_pkg::ADR_CNT1: s_d.counter_one = i_wb_sel[1] ? i_wb_dat[15:0]
                                                          : {s_q.counter_one[15:8], i_wb_dat[7:0]};
        dtpc_pkg::ADR_CNT2: s_d.counter_two = i_wb_sel[1] ? i_wb_dat[15:0]
                                                          : {s_q.counter_two[15:8], i_wb_dat[7:0]};
        dtpc_pkg::ADR_RCA: s_d.reload_capture_a = i_wb_sel[1] ? i_wb_dat[15:0]
                                                  : {s_q.reload_capture_a[15:8], i_wb_dat[7:0]};
        dtpc_pkg::ADR_RB: s_d.reload_b = i_wb_sel[1] ? i_wb_dat[15:0]
                                                     : {s_q.reload_b[15:8], i_wb_dat[7:0]};
        dtpc_pkg::ADR_MODE: begin
          s_d.mode_select_field     = i_wb_dat[dtpc_pkg::MODE_LSB +: 2];
          s_d.capture_edge_polarity = i_wb_dat[dtpc_pkg::EDGE_BIT];
          s_d.pin_toggle_enable     = i_wb_dat[dtpc_pkg::TOGGLE_EN_BIT];
          s_d.pin_initial_level     = i_wb_dat[dtpc_pkg::INIT_LEVEL_BIT];
          s_d.timer_pin             = i_wb_dat[dtpc_pkg::INIT_LEVEL_BIT];
        end
        dtpc_pkg::ADR_INTCTL: s_d.int_enable = i_wb_dat[dtpc_pkg::IEN_LSB +: 4];
        default: begin
        end
      endcase
    end

    // pending: write-one-to-clear, a same-cycle event wins over the clear
    s_d.pending = (s_q.pending & ~(clr_wr ? i_wb_dat[dtpc_pkg::PND_LSB +: 4] : 4'h0))
                  | set_pnd;

    case (i_wb_adr)
      dtpc_pkg::ADR_PRESCALE: rd_val = {27'h0, s_q.prescale_divisor};
      dtpc_pkg::ADR_CLKSEL:   rd_val = {26'h0, s_q.second_counter_clock_sel,
                                        s_q.first_counter_clock_sel};
      dtpc_pkg::ADR_CNT1:     rd_val = {16'h0, s_q.counter_one};
      dtpc_pkg::ADR_CNT2:     rd_val = {16'h0, s_q.counter_two};
      dtpc_pkg::ADR_RCA:      rd_val = {16'h0, s_q.reload_capture_a};
      dtpc_pkg::ADR_RB:       rd_val = {16'h0, s_q.reload_b};
      dtpc_pkg::ADR_MODE:     rd_val = {25'h0, s_q.pin_initial_level, 1'b0,
                                        s_q.pin_toggle_enable, 1'b0,
                                        s_q.capture_edge_polarity, s_q.mode_select_field};
      dtpc_pkg::ADR_INTCTL:   rd_val = {24'h0, s_q.pending, s_q.int_enable};
      default:                rd_val = 32'h0000_0000;  // unmapped reads zero, still acked
    endcase
    s_d.ack = (i_wb_cyc && i_wb_stb && !s_q.ack);
    s_d.rdata = rd ? rd_val : s_q.rdata;
  end

  // synchronous reset; counters and reload registers clear to zero like every other register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;  // nothing moves while the clock is stopped
    end
  end

  assign o_wb_dat = s_q.rdata;
  assign o_wb_ack = s_q.ack;
  assign o_timer_pin = s_q.timer_pin;
  // pin drives only as a toggling output outside capture mode
  assign o_timer_pin_oe_n = !(s_q.pin_toggle_enable &&
                              s_q.mode_select_field != dtpc_pkg::MODE_CAPT);
  logic c_enable;
  // in dual mode source c answers to the a enable, elsewhere to its own
  assign c_enable = (s_q.mode_select_field == dtpc_pkg::MODE_DUAL) ? s_q.int_enable[0]
                                                                   : s_q.int_enable[2];
  assign o_timer_irq_one_line = |(s_q.pending[1:0] & s_q.int_enable[1:0])
                                | (s_q.pending[2] & c_enable);
  assign o_timer_irq_two_line = s_q.pending[3] & s_q.int_enable[3];
endmodule
`default_nettype wire

// ===== design/dtpc_pkg.sv
// package for the dual timer with pwm and capture
// assumes a wishbone classic slave with 32-bit data, registers one word each
package dtpc_pkg;
  localparam logic [7:0] ADR_PRESCALE = 8'h00;
  localparam logic [7:0] ADR_CLKSEL   = 8'h04;
  localparam logic [7:0] ADR_CNT1     = 8'h08;
  localparam logic [7:0] ADR_CNT2     = 8'h0C;
  localparam logic [7:0] ADR_RCA      = 8'h10;
  localparam logic [7:0] ADR_RB       = 8'h14;
  localparam logic [7:0] ADR_MODE     = 8'h18;
  localparam logic [7:0] ADR_INTCTL   = 8'h1C;
  localparam logic [7:0] ADR_INTCLR   = 8'h20;
  localparam logic [4:0] PRESCALE_RST = 5'h00;
  localparam logic [2:0] CSEL_NONE    = 3'h0;
  localparam logic [2:0] CSEL_PRESC   = 3'h1;
  localparam logic [2:0] CSEL_SLOW    = 3'h4;
  localparam logic [1:0] MODE_PWM     = 2'h0;
  localparam logic [1:0] MODE_CAPT    = 2'h1;
  localparam logic [1:0] MODE_DUAL    = 2'h2;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  // mode register bit positions
  localparam int MODE_LSB       = 0;
  localparam int EDGE_BIT       = 2;
  localparam int TOGGLE_EN_BIT  = 4;
  localparam int INIT_LEVEL_BIT = 6;
  // interrupt control: enables in 3:0, pendings in 7:4 (a,b,c,d)
  localparam int IEN_LSB = 0;
  localparam int PND_LSB = 4;

  typedef struct packed {
    logic [4:0]  prescale_divisor;
    logic [4:0]  presc_cnt;
    logic [2:0]  first_counter_clock_sel;
    logic [2:0]  second_counter_clock_sel;
    logic [15:0] counter_one;
    logic [15:0] counter_two;
    logic [15:0] reload_capture_a;
    logic [15:0] reload_b;
    logic [1:0]  mode_select_field;
    logic        capture_edge_polarity;
    logic        pin_toggle_enable;
    logic        pin_initial_level;
    logic        timer_pin;
    logic        next_from_b;
    logic [3:0]  int_enable;
    logic [3:0]  pending;
    logic [2:0]  slow_sync;
    logic [2:0]  pin_sync;
    logic        slow_lvl;
    logic        pin_lvl;
    logic        ack;
    logic [31:0] rdata;
  } dtpc_state_t;
endpackage

// ===== testbench/dtpc_monitor.sv
// port checker for the dual timer
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dtpc_monitor (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_timer_pin,
  input wire logic        o_timer_pin_oe_n,
  input wire logic        o_timer_irq_one_line,
  input wire logic        o_timer_irq_two_line
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic req;
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  a_ack_follows: assert property (req |=> o_wb_ack) else $error("ack missing");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_unmapped_zero: assert property (req && !i_wb_we && i_wb_adr == 8'h40
    |=> o_wb_dat == 32'h0000_0000) else $error("unmapped read not zero");
  a_reset_idle: assert property ($rose(i_rst_n) |-> o_timer_pin_oe_n && !o_timer_pin
    && !o_timer_irq_one_line && !o_timer_irq_two_line) else $error("not idle after reset");
  a_pin_cause: assert property ($changed(o_timer_pin)
    |-> o_wb_ack || !$past(o_timer_pin_oe_n) || !$past(i_rst_n)) else $error("pin moved");
  a_irq_one_fall: assert property ($fell(o_timer_irq_one_line)
    |-> o_wb_ack || !$past(i_rst_n)) else $error("irq one dropped");
  a_irq_two_fall: assert property ($fell(o_timer_irq_two_line)
    |-> o_wb_ack || !$past(i_rst_n)) else $error("irq two dropped");
endmodule
bind dtpc_timer dtpc_monitor i_dtpc_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_timer_pin(o_timer_pin),
  .o_timer_pin_oe_n(o_timer_pin_oe_n), .o_timer_irq_one_line(o_timer_irq_one_line),
  .o_timer_irq_two_line(o_timer_irq_two_line));
`default_nettype wire

// ===== testbench/dtpc_pin_model.sv
// far side of the timer pin: capture source and free-running slow clock
// assumes oe_n low whenever the device drives the pin
`timescale 1ns/1ps
`default_nettype none
module dtpc_pin_model (
  input  wire logic i_clk,
  input  wire logic i_level,
  input  wire logic i_dev_pin,
  input  wire logic i_dev_oe_n,
  output logic      o_wire,
  output logic      o_slow_clk
);
  logic lvl_q;
  // level moves only on a system edge, so every pulse lasts whole cycles
  always_ff @(posedge i_clk) lvl_q <= i_level;
  assign o_wire = i_dev_oe_n ? lvl_q : i_dev_pin;
  // one eighth of the system rate keeps the synchroniser margin
  initial begin
    o_slow_clk = 1'b0;
    forever #40 o_slow_clk = ~o_slow_clk;
  end
endmodule
`default_nettype wire

// ===== testbench/test_dtpc_timer.sv
// self-checking bench for the dual timer
// assumes a wishbone slave answering one cycle after a request
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t got %h expected %h", $time, (g), (e)); end end
module test_dtpc_timer;
  logic        clk, rst_n, cyc, stb, we, ack, pin_o, oe_n, irq1, irq2, src, slow, pin_w;
  logic [3:0]  sel, lanes;
  logic [7:0]  adr;
  logic [31:0] dat, rdat;
  int          err_total, total_checks;
  dtpc_timer i_dtpc_timer (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_slow_clk(slow), .i_timer_pin(pin_w), .o_timer_pin(pin_o),
    .o_timer_pin_oe_n(oe_n), .o_timer_irq_one_line(irq1), .o_timer_irq_two_line(irq2));
  dtpc_pin_model i_dtpc_pin_model (.i_clk(clk), .i_level(src), .i_dev_pin(pin_o),
    .i_dev_oe_n(oe_n), .o_wire(pin_w), .o_slow_clk(slow));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    dat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) err_total++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 16'h0000, q);
  endtask
  // cycles until the pin level changes; bounded so a stuck pin cannot hang
  task automatic span(output int n);
    logic p;
    p = pin_o;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pin_o === p && n < 300);
  endtask
  task automatic t_reset;
    logic [7:0]  al [5] = '{dtpc_pkg::ADR_PRESCALE, dtpc_pkg::ADR_CLKSEL,
                            dtpc_pkg::ADR_MODE, dtpc_pkg::ADR_INTCTL, 8'h40};
    logic [31:0] q;
    foreach (al[i]) begin
      rd(al[i], q);
      `CHK(q, 32'h0000_0000)
    end
    wr(dtpc_pkg::ADR_CNT1, 16'h1234);
    repeat (20) @(posedge clk);
    rd(dtpc_pkg::ADR_CNT1, q);
    `CHK(q, 32'h0000_1234)
    // lane one off: only the low byte of the halted counter is written
    lanes = 4'h1;
    wr(dtpc_pkg::ADR_CNT1, 16'hAB56);
    lanes = 4'hF;
    rd(dtpc_pkg::ADR_CNT1, q);
    `CHK(q, 32'h0000_1256)
    $display("reset test finished");
  endtask
  task automatic t_presc(input logic [4:0] dv);
    logic [31:0] a, b;
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0000);
    wr(dtpc_pkg::ADR_PRESCALE, {11'h000, dv});
    wr(dtpc_pkg::ADR_MODE, 16'h0000);
    wr(dtpc_pkg::ADR_CNT1, 16'h8000);
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0001);
    rd(dtpc_pkg::ADR_CNT1, a);
    // the read itself spans three cycles, taken off the wait
    repeat (64 * (int'(dv) + 1) - 3) @(posedge clk);
    rd(dtpc_pkg::ADR_CNT1, b);
    `CHK((a[15:0] - b[15:0]) inside {[16'h003F:16'h0041]}, 1'b1)
    $display("prescale test finished");
  endtask
  task automatic t_pwm;
    int          lo, hi;
    logic [31:0] a, b;
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0000);
    wr(dtpc_pkg::ADR_INTCLR, 16'h00F0);
    wr(dtpc_pkg::ADR_PRESCALE, 16'h0000);
    wr(dtpc_pkg::ADR_RCA, 16'h0003);
    wr(dtpc_pkg::ADR_RB, 16'h0007);
    wr(dtpc_pkg::ADR_CNT1, 16'h0010);
    wr(dtpc_pkg::ADR_MODE, 16'h0050);
    `CHK(pin_o, 1'b1)
    `CHK(oe_n, 1'b0)
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0001);
    span(lo);
    span(lo);
    span(hi);
    `CHK(lo, 4)
    `CHK(hi, 8)
    rd(dtpc_pkg::ADR_INTCTL, a);
    `CHK(a[5:4], 2'b11)
    wr(dtpc_pkg::ADR_INTCTL, 16'h0001);
    `CHK(irq1, 1'b1)
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0000);
    rd(dtpc_pkg::ADR_CNT1, a);
    repeat (8) @(posedge clk);
    rd(dtpc_pkg::ADR_CNT1, b);
    `CHK(b, a)
    wr(dtpc_pkg::ADR_INTCLR, 16'h00F0);
    `CHK(irq1, 1'b0)
    $display("pwm test finished");
  endtask
  task automatic t_capt(input logic pol);
    logic [31:0] q;
    src <= pol;
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0000);
    wr(dtpc_pkg::ADR_INTCLR, 16'h00F0);
    wr(dtpc_pkg::ADR_PRESCALE, 16'h0000);
    wr(dtpc_pkg::ADR_CNT2, 16'h0005);
    wr(dtpc_pkg::ADR_MODE, {13'h0000, pol, 2'b01} | 16'h0010);
    `CHK(oe_n, 1'b1)
    wr(dtpc_pkg::ADR_INTCTL, 16'h0009);
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0009);
    // inactive, active, inactive, active: active pair 50 apart, inactive pair 40 apart,
    // so a wrong polarity shows; pulses outlast a slow clock period
    for (int k = 0; k < 4; k++) begin
      src <= ~src;
      repeat ((k == 2) ? 30 : 20) @(posedge clk);
    end
    rd(dtpc_pkg::ADR_RCA, q);
    `CHK(q[15:0] inside {[16'hFFCC:16'hFFD0]}, 1'b1)
    rd(dtpc_pkg::ADR_INTCTL, q);
    `CHK(q[7:4] & 4'h9, 4'h9)
    `CHK(irq2, 1'b1)
    $display("capture test finished");
  endtask
  task automatic t_dual;
    int          lo, hi;
    logic [31:0] q;
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0000);
    wr(dtpc_pkg::ADR_INTCLR, 16'h00F0);
    wr(dtpc_pkg::ADR_PRESCALE, 16'h0000);
    wr(dtpc_pkg::ADR_CNT1, 16'h0000);
    wr(dtpc_pkg::ADR_RCA, 16'h0004);
    wr(dtpc_pkg::ADR_RB, 16'h0009);
    wr(dtpc_pkg::ADR_CNT2, 16'h0000);
    wr(dtpc_pkg::ADR_MODE, 16'h0012);
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0009);
    span(lo);
    span(hi);
    span(lo);
    `CHK(hi, 5)
    `CHK(lo, 5)
    rd(dtpc_pkg::ADR_INTCTL, q);
    `CHK(q[7:6], 2'b11)
    wr(dtpc_pkg::ADR_INTCTL, 16'h0001);
    `CHK(irq1, 1'b1)
    `CHK(irq2, 1'b0)
    rd(dtpc_pkg::ADR_CNT2, q);
    `CHK(q[15:0] <= 16'h0009, 1'b1)
    $display("dual test finished");
  endtask
  task automatic t_slow;
    logic [31:0] a, b;
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0000);
    wr(dtpc_pkg::ADR_MODE, 16'h0000);
    wr(dtpc_pkg::ADR_CNT2, 16'h8000);
    wr(dtpc_pkg::ADR_CLKSEL, 16'h0020);
    rd(dtpc_pkg::ADR_CNT2, a);
    repeat (157) @(posedge clk);
    rd(dtpc_pkg::ADR_CNT2, b);
    `CHK((a[15:0] - b[15:0]) inside {[16'h0013:16'h0015]}, 1'b1)
    $display("slow clock test finished");
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    sel = 4'hF;
    lanes = 4'hF;
    src = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_presc(5'h00);
    t_presc(5'h03);
    t_presc(5'h1F);
    t_pwm();
    t_pwm();
    t_capt(1'b0);
    t_capt(1'b1);
    t_dual();
    t_slow();
    end_sim();
  end
endmodule
`default_nettype wire
